// File: bench/lfs_partner.sv
`timescale 1ns/1ps
// Modulator period, auxiliary ringing and sense overshoot.
module lfs_partner (
   // Clock.
   input wire ref_clk,
   // Fault injection.
   input wire aux_short,
   input wire wind_short,
   // Events to the supervisor.
   output reg period_start = 1'b0,
   output reg drive_request = 1'b0,
   output reg zcd_above_short = 1'b0,
   output reg cs_over_stop = 1'b0
);
   reg [2:0] cnt_q = 3'h0;
   // Eight-cycle period; an auxiliary short kills the ringing.
   always @(posedge ref_clk) begin
      cnt_q <= cnt_q + 3'h1;
      period_start <= (cnt_q == 3'h7);
      drive_request <= (cnt_q < 3'h4);
      zcd_above_short <= !aux_short && (cnt_q == 3'h5);
      cs_over_stop <= wind_short;
   end
endmodule // lfs_partner

// File: bench/lfs_props_properties.sv
`timescale 1ns/1ps
// Port checks on the fault supervisor.
module lfs_props (
   // Clock and reset.
   input wire ref_clk,
   input wire nrst,
   // Inputs.
   input wire drive_request,
   input wire supply_ovp,
   input wire brownout_low_level,
   input wire die_overtemp,
   // Outputs.
   input wire drive_enable_q,
   input wire [7:0] current_ref_q,
   input wire startup_supply_current_q,
   input wire fault_q,
   input wire die_overtemp_fault_q,
   input wire brownout_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Supply OVP needs the synchroniser, the policy flop and fault_q, so
   // four samples; the die flag is one stage shorter, so three.
   sequence ovp_held;
      supply_ovp [*4];
   endsequence
   sequence die_held;
      die_overtemp [*3];
   endsequence
   reset_vals_a: assert property ($rose(nrst) |->
      !drive_enable_q && !fault_q && !brownout_q && startup_supply_current_q
      && current_ref_q == 8'hFF) else $error("bad reset state");
   fault_gate_a: assert property (
      fault_q && $past(fault_q) |-> !drive_enable_q) else $error("drive in fault");
   ref_floor_a: assert property (current_ref_q >= 8'h80)
      else $error("reference below half");
   bo_gate_a: assert property (
      brownout_q && $past(brownout_q) |-> !drive_enable_q) else $error("bo drive");
   drive_cause_a: assert property (
      $rose(drive_enable_q) |-> $past(drive_request)) else $error("drive cause");
   bo_delay_a: assert property (
      $rose(brownout_q) |-> $past(brownout_low_level, 4)) else $error("bo early");
   ovp_fault_a: assert property (ovp_held |=> fault_q)
      else $error("ovp no fault");
   die_trip_a: assert property (die_held |=> die_overtemp_fault_q)
      else $error("die no fault");
endmodule // lfs_props
bind lfs_supervisor lfs_props u_props (.ref_clk(ref_clk), .nrst(nrst),
   .drive_request(drive_request), .supply_ovp(supply_ovp),
   .brownout_low_level(brownout_low_level), .die_overtemp(die_overtemp),
   .drive_enable_q(drive_enable_q), .current_ref_q(current_ref_q),
   .startup_supply_current_q(startup_supply_current_q), .fault_q(fault_q),
   .die_overtemp_fault_q(die_overtemp_fault_q), .brownout_q(brownout_q));

// File: bench/lfs_supervisor_tb.sv
`timescale 1ns/1ps
module lfs_supervisor_tb;
   reg ref_clk = 1'b0;
   reg nrst, lat, vst, ovp, fst, fsp, trp, rel, povp, bol, boh;
   reg die, dier, csz, gnd, ash, wsh, r;
   reg [7:0] frac;
   wire drv, sst, flt, dflt, wflt, aflt, bo, prd, req, zcd, ovs;
   wire [7:0] cref;
   integer n_mismatch = 0;
   integer checks_done = 0;
   integer i;
   always #5 ref_clk = ~ref_clk;
   lfs_supervisor #(.BO_CYC(32'h32), .AUX_CYC(32'h32), .AR_CYC(32'h32)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .latching_variant(lat),
      .supply_start_level(vst), .supply_ovp(ovp),
      .foldback_start_level(fst), .foldback_stop_level(fsp),
      .foldback_frac(frac), .otp_trip(trp), .otp_release(rel),
      .thermistor_pin_overvoltage(povp), .brownout_low_level(bol),
      .brownout_high_level(boh), .die_overtemp(die),
      .die_overtemp_release(dier), .cs_low_impedance(csz),
      .cs_over_stop(ovs), .ground_loss(gnd), .zcd_above_short(zcd),
      .period_start(prd), .drive_request(req), .drive_enable_q(drv),
      .current_ref_q(cref), .startup_supply_current_q(sst),
      .fault_q(flt), .die_overtemp_fault_q(dflt),
      .diode_winding_short_fault_q(wflt),
      .auxiliary_short_fault_q(aflt), .brownout_q(bo));
   lfs_partner prt (.ref_clk(ref_clk), .aux_short(ash),
      .wind_short(wsh), .period_start(prd), .drive_request(req),
      .zcd_above_short(zcd), .cs_over_stop(ovs));
   task chk8(input string w, input [7:0] e, input [7:0] g);
      checks_done = checks_done + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %s exp %h got %h", w, e, g);
      end
   endtask
   task chk1(input string w, input e, input g);
      chk8(w, {7'h00, e}, {7'h00, g});
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge ref_clk);
   endtask
   // Reset for five cycles, then raise the supply start flag.
   task rst(input l);
      nrst = 1'b0;
      lat = l;
      vst = 1'b0;
      {ovp, fst, fsp, trp, rel, povp, bol, boh} = 8'h00;
      {die, dier, csz, gnd, ash, wsh} = 6'h00;
      frac = 8'hFF;
      cyc(5);
      nrst = 1'b1;
      cyc(2);
      vst = 1'b1;
      cyc(4);
   endtask
   // Drive must mirror the request one cycle later when enabled.
   task drvchk(input en);
      for (i = 0; i < 8; i = i + 1) begin
         r = req & en;
         cyc(1);
         chk1("drv", r, drv);
      end
   endtask
   task t_ovp;
      drvchk(1'b1);
      ovp = 1'b1;
      cyc(5);
      chk1("flt", 1'b1, flt);
      drvchk(1'b0);
      ovp = 1'b0;
      cyc(25);
      chk1("flt", 1'b1, flt);
      cyc(60);
      chk1("flt", 1'b0, flt);
   endtask
   task t_bo;
      bol = 1'b1;
      cyc(40);
      chk1("bo", 1'b0, bo);
      cyc(20);
      chk1("bo", 1'b1, bo);
      bol = 1'b0;
      vst = 1'b0;
      boh = 1'b1;
      cyc(5);
      chk1("bo", 1'b1, bo);
      chk1("sst", 1'b1, sst);
      vst = 1'b1;
      cyc(5);
      chk1("bo", 1'b0, bo);
   endtask
   task t_fold;
      fst = 1'b1;
      frac = 8'hC0;
      cyc(5);
      chk8("ref", 8'hC0, cref);
      fsp = 1'b1;
      cyc(5);
      chk8("ref", 8'h80, cref);
   endtask
   task t_die;
      die = 1'b1;
      cyc(5);
      chk1("flt", 1'b1, flt);
      die = 1'b0;
      cyc(100);
      chk1("die", 1'b1, dflt);
      dier = 1'b1;
      cyc(100);
      chk1("die", 1'b0, dflt);
   endtask
   task t_latch;
      rst(1'b1);
      povp = 1'b1;
      cyc(5);
      povp = 1'b0;
      cyc(100);
      chk1("flt", 1'b1, flt);
      rst(1'b0);
      chk1("flt", 1'b0, flt);
   endtask
   task t_otp;
      rst(1'b1);
      trp = 1'b1;
      cyc(100);
      chk1("flt", 1'b0, flt);
      cyc(25000);
      chk1("flt", 1'b1, flt);
      trp = 1'b0;
      rel = 1'b1;
      cyc(100);
      chk1("flt", 1'b1, flt);
      rst(1'b0);
      trp = 1'b1;
      cyc(25100);
      chk1("flt", 1'b1, flt);
      trp = 1'b0;
      cyc(100);
      chk1("flt", 1'b1, flt);
      rel = 1'b1;
      cyc(100);
      chk1("flt", 1'b0, flt);
   endtask
   task t_short;
      rst(1'b0);
      ash = 1'b1;
      cyc(120);
      chk1("aux", 1'b1, aflt);
      rst(1'b0);
      wsh = 1'b1;
      cyc(60);
      chk1("wod", 1'b1, wflt);
   endtask
   task t_pins;
      rst(1'b0);
      vst = 1'b0;
      csz = 1'b1;
      cyc(3);
      vst = 1'b1;
      cyc(5);
      drvchk(1'b0);
      rst(1'b0);
      gnd = 1'b1;
      cyc(20010);
      drvchk(1'b0);
   endtask
   task test_done;
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      rst(1'b0);
      t_ovp;
      t_bo;
      t_fold;
      t_die;
      t_latch;
      t_otp;
      t_short;
      t_pins;
      test_done;
   end
   // Whole run is near 71300 cycles.
   initial begin
      #850000;
      n_mismatch = n_mismatch + 1;
      test_done;
   end
endmodule // lfs_supervisor_tb

// File: logic/lfs_defs.vh
// Overview of operation
// - Foldback lowers current reference to half nominal.
// - Thermistor trip faults until release threshold.
// - Latching variant also needs supply clear.
// - Blank thermistor trip 250 us after start.
// - Brown-out after 25 ms low flag.
// - Resume when line high and supply started.
// - Brown-out recovery requests start-up current.
// - Die over-temperature stops until release.
// - Check sense impedance at start, max on-time.
// - Ground-loss for 200 us stops drive.
// - Listed severe conditions enter fault mode.
// - Fault mode suppresses all drive pulses.
// - Latching fault clears on supply clear.
// - Auto-recovery waits 4 s, then supply start.
// - Variant selects latching or auto-recovery policy.
// - Auxiliary short after 90 ms without pulse.
// - Diode short after four consecutive overshoots.
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH
`define LFS_CLK_MHZ 100
`define LFS_BLANK_US 250
`define LFS_BLANK_CYC (`LFS_BLANK_US * `LFS_CLK_MHZ)
`define LFS_BO_MS 25
`define LFS_BO_CYC (`LFS_BO_MS * 1000 * `LFS_CLK_MHZ)
`define LFS_GND_US 200
`define LFS_GND_CYC (`LFS_GND_US * `LFS_CLK_MHZ)
`define LFS_AUX_MS 90
`define LFS_AUX_CYC (`LFS_AUX_MS * 1000 * `LFS_CLK_MHZ)
`define LFS_AR_S 4
`define LFS_AR_CYC (`LFS_AR_S * 1000000 * `LFS_CLK_MHZ)
`define LFS_MAXON_US 36
`define LFS_MAXON_CYC (`LFS_MAXON_US * `LFS_CLK_MHZ)
`define LFS_SCP_COUNT 3'h4
`define LFS_NSYNC 12
`define LFS_REF_FULL 8'hFF
`define LFS_REF_HALF 8'h80
`define LFS_CNT_W 32
`endif

// File: logic/lfs_supervisor.v
`timescale 1ns/1ps
`include "lfs_defs.vh"
// Fault supervisor: gates drive pulses, scales the current reference.
module lfs_supervisor #(
   parameter [`LFS_CNT_W-1:0] BO_CYC = `LFS_BO_CYC,
   parameter [`LFS_CNT_W-1:0] AUX_CYC = `LFS_AUX_CYC,
   parameter [`LFS_CNT_W-1:0] AR_CYC = `LFS_AR_CYC
) (
   // Clock and reset (reset is the supply clear level).
   input wire ref_clk,
   input wire nrst,
   // Static variant strap: 1 selects latching policy.
   input wire latching_variant,
   // Supply comparators.
   input wire supply_start_level,
   input wire supply_ovp,
   // Thermistor pin comparators.
   input wire foldback_start_level,
   input wire foldback_stop_level,
   input wire [7:0] foldback_frac,
   input wire otp_trip,
   input wire otp_release,
   input wire thermistor_pin_overvoltage,
   // Line sense comparators.
   input wire brownout_low_level,
   input wire brownout_high_level,
   // Die temperature comparators.
   input wire die_overtemp,
   input wire die_overtemp_release,
   // Current sense and pin checks.
   input wire cs_low_impedance,
   input wire cs_over_stop,
   input wire ground_loss,
   input wire zcd_above_short,
   // Switching events from the modulator.
   input wire period_start,
   input wire drive_request,
   // Outputs.
   output reg drive_enable_q,
   output reg [7:0] current_ref_q,
   output reg startup_supply_current_q,
   output reg fault_q,
   output reg die_overtemp_fault_q,
   output reg diode_winding_short_fault_q,
   output reg auxiliary_short_fault_q,
   output reg brownout_q
);
   ////////////////////////////////////////////////////////////////////////
   // Synchronisation.
   wire [`LFS_NSYNC-1:0] s;
   lfs_sync u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .raw({supply_start_level, supply_ovp, otp_trip, otp_release,
            thermistor_pin_overvoltage, brownout_low_level,
            brownout_high_level, die_overtemp, die_overtemp_release,
            cs_low_impedance, cs_over_stop, ground_loss}),
      .sync_q(s)
   );
   // Named views of the synchronised flags.
   wire s_start = s[11];
   wire s_ovp = s[10];
   wire s_otp = s[9];
   wire s_otp_rel = s[8];
   wire s_pin_ovp = s[7];
   wire s_bo_low = s[6];
   wire s_bo_high = s[5];
   wire s_tsd = s[4];
   wire s_tsd_rel = s[3];
   wire s_cs_low = s[2];
   wire s_cs_stop = s[1];
   wire s_gnd = s[0];

   // Saturating increment shared by every qualification timer.
   function [`LFS_CNT_W-1:0] inc_sat;
      input [`LFS_CNT_W-1:0] v;
      begin
         inc_sat = (v == {`LFS_CNT_W{1'b1}}) ? v : v + 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State.
   reg latch_mode_q; // Captured variant.
   reg started_q; // Supply has reached its start level once.
   reg start_prev_q; // For the start edge.
   reg [`LFS_CNT_W-1:0] blank_q, bo_q, gnd_q, aux_q, ar_q, on_q;
   reg [2:0] scp_q; // Consecutive overshoot periods.
   reg ovshoot_q; // Overshoot seen in current period.
   reg otp_q; // Thermistor over-temperature latched.
   reg latched_q; // A latching fault is held.
   reg auto_q; // An auto-recovery fault is timing out.
   reg cs_fault_q, gnd_fault_q; // Pin connection faults.
   reg chk_q; // Impedance check pending.

   wire start_rise = s_start & ~start_prev_q;
   wire blanked = (blank_q != 32'h0);
   wire new_otp = s_otp & ~blanked;
   wire new_aux = (aux_q >= AUX_CYC);
   wire new_scp = (scp_q >= `LFS_SCP_COUNT);
   // Latching variant latches thermistor, pin OVP and both shorts.
   wire latch_ev = latch_mode_q &
      (new_otp | s_pin_ovp | new_aux | new_scp);
   // Remaining events auto-recover; all events do in the other variant.
   wire auto_ev = s_ovp | s_tsd | (~latch_mode_q &
      (new_otp | s_pin_ovp | new_aux | new_scp));
   wire any_fault = latched_q | auto_q | otp_q | die_overtemp_fault_q |
      brownout_q | cs_fault_q | gnd_fault_q;

   ////////////////////////////////////////////////////////////////////////
   // Timers, fault latches and policy.
   always @(posedge ref_clk) begin
      if (!nrst) begin
         // Supply clear: every latched fault is released here.
         latch_mode_q <= 1'b0;
         started_q <= 1'b0;
         start_prev_q <= 1'b0;
         blank_q <= 32'h0;
         bo_q <= 32'h0;
         gnd_q <= 32'h0;
         aux_q <= 32'h0;
         ar_q <= 32'h0;
         on_q <= 32'h0;
         scp_q <= 3'h0;
         ovshoot_q <= 1'b0;
         otp_q <= 1'b0;
         latched_q <= 1'b0;
         auto_q <= 1'b0;
         cs_fault_q <= 1'b0;
         gnd_fault_q <= 1'b0;
         chk_q <= 1'b1;
         die_overtemp_fault_q <= 1'b0;
         diode_winding_short_fault_q <= 1'b0;
         auxiliary_short_fault_q <= 1'b0;
         brownout_q <= 1'b0;
         startup_supply_current_q <= 1'b1;
      end else begin
         start_prev_q <= s_start;
         // Strap is followed until the supply first starts, then held.
         if (!started_q)
            latch_mode_q <= latching_variant;
         if (start_rise) begin
            started_q <= 1'b1;
            blank_q <= `LFS_BLANK_CYC;
            chk_q <= 1'b1;
         end else if (blanked) begin
            blank_q <= blank_q - 1'b1;
         end
         // Thermistor trip holds until release level.
         if (new_otp)
            otp_q <= 1'b1;
         else if (s_otp_rel && !latched_q)
            otp_q <= 1'b0;
         // Pin over-voltage acts at once through the policy terms below.
         // Brown-out qualification and recovery.
         bo_q <= s_bo_low ? inc_sat(bo_q) : 32'h0;
         if (bo_q > BO_CYC)
            brownout_q <= 1'b1;
         else if (brownout_q && s_bo_high && s_start)
            brownout_q <= 1'b0;
         startup_supply_current_q <= (bo_q > BO_CYC) |
            (brownout_q & ~s_start) | ~started_q;
         // Die over-temperature with hysteresis.
         if (s_tsd)
            die_overtemp_fault_q <= 1'b1;
         else if (s_tsd_rel)
            die_overtemp_fault_q <= 1'b0;
         // Impedance check at start and after max on-time.
         on_q <= drive_enable_q ? inc_sat(on_q) : 32'h0;
         if (on_q == `LFS_MAXON_CYC)
            chk_q <= 1'b1;
         if (chk_q && started_q) begin
            chk_q <= 1'b0;
            if (s_cs_low)
               cs_fault_q <= 1'b1;
         end
         // Ground loss persistence.
         gnd_q <= s_gnd ? inc_sat(gnd_q) : 32'h0;
         if (gnd_q >= `LFS_GND_CYC)
            gnd_fault_q <= 1'b1;
         // Auxiliary short timer counts only while operating.
         if (zcd_above_short)
            aux_q <= 32'h0;
         else if (drive_enable_q)
            aux_q <= inc_sat(aux_q);
         auxiliary_short_fault_q <= auxiliary_short_fault_q | new_aux;
         // Overshoot per switching period.
         if (period_start) begin
            scp_q <= ovshoot_q ? scp_q + 3'h1 : 3'h0;
            ovshoot_q <= s_cs_stop;
         end else if (s_cs_stop) begin
            ovshoot_q <= 1'b1;
         end
         diode_winding_short_fault_q <= diode_winding_short_fault_q | new_scp;
         // Policy.
         if (latch_ev)
            latched_q <= 1'b1;
         if (auto_ev) begin
            auto_q <= 1'b1;
            ar_q <= 32'h0;
            aux_q <= 32'h0;
            scp_q <= 3'h0;
         end else if (auto_q) begin
            ar_q <= inc_sat(ar_q);
            if (ar_q >= AR_CYC && s_start) begin
               auto_q <= 1'b0;
               // A latched short keeps its flag, and a new short wins
               // over the release in the same cycle.
               auxiliary_short_fault_q <= new_aux |
                  (latch_mode_q & auxiliary_short_fault_q);
               diode_winding_short_fault_q <= new_scp |
                  (latch_mode_q & diode_winding_short_fault_q);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs: drive gating and foldback reference.
   always @(posedge ref_clk) begin
      if (!nrst) begin
         drive_enable_q <= 1'b0;
         fault_q <= 1'b0;
         current_ref_q <= `LFS_REF_FULL;
      end else begin
         fault_q <= any_fault;
         drive_enable_q <= drive_request & started_q & ~any_fault &
            ~auto_ev & ~latch_ev;
         // Linear foldback between start and stop, floor at half.
         if (foldback_stop_level)
            current_ref_q <= `LFS_REF_HALF;
         else if (foldback_start_level)
            current_ref_q <= (foldback_frac < `LFS_REF_HALF) ?
               `LFS_REF_HALF : foldback_frac;
         else
            current_ref_q <= `LFS_REF_FULL;
      end
   end
endmodule // lfs_supervisor

// File: logic/lfs_sync.v
`timescale 1ns/1ps
`include "lfs_defs.vh"
// Two-stage synchroniser for a bundle of comparator flags.
module lfs_sync (
   // Clock and reset.
   input wire ref_clk,
   input wire nrst,
   // Raw and synchronised flags.
   input wire [`LFS_NSYNC-1:0] raw,
   output reg [`LFS_NSYNC-1:0] sync_q
);
   reg [`LFS_NSYNC-1:0] meta_q; // First stage, read only by sync_q.

   // Stage one feeds stage two and nothing else.
   always @(posedge ref_clk) begin
      if (!nrst) begin
         meta_q <= {`LFS_NSYNC{1'b0}};
         sync_q <= {`LFS_NSYNC{1'b0}};
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end
endmodule // lfs_sync
